// ---- rtl/lfr_regs.svh ----
// Purpose: offsets, field positions and reset values of the fault
//          flag and output current setting registers
// Assumes: 8-bit register data, byte offsets as seen by the serial port
// Notes:   definitions only
// Functional notes
// - Bits 3..0 at 7Ch hold the open faults of channels 11..8, 1 = fault.
// - Bits 7..0 at 7Dh hold the short faults of channels 7..0, 1 = fault.
// - Bits 3..0 at 7Eh hold short faults of channels 11..8; 7..4 read 0.
// - The three flag registers are read-only, reset to 0; 7Ch and 7Eh read 0 in 7..4.
// - Current codes are 6-bit R/W in bits 5..0, reset 3Fh; 7..6 read 0.
// - Current settings for outputs 0, 1, 2 sit at 80h, 81h and 82h.
`ifndef LFR_REGS_SVH
`define LFR_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LFR_OFS_OPEN_HI 8'h7c
`define LFR_OFS_SHORT_LO 8'h7d
`define LFR_OFS_SHORT_HI 8'h7e
`define LFR_OFS_CUR_ZERO 8'h80
`define LFR_OFS_CUR_ONE 8'h81
`define LFR_OFS_CUR_TWO 8'h82

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define LFR_CUR_MSB 5
`define LFR_CUR_W 6
`define LFR_CUR_ENTRIES 3
`define LFR_CUR_RST 6'h3f
`define LFR_FLAG_RST 8'h00
`define LFR_HI_FLAG_W 4
`define LFR_LO_FLAG_W 8
`define LFR_RSVD_CUR 2'h0
`define LFR_RSVD_HI 4'h0
`define LFR_RD_NONE 8'h00

`endif

// ---- rtl/lfr_pkg.sv ----
// Purpose: shared types of the fault flag and current register slice
// Assumes: lfr_regs.svh holds every number
// Notes:   read source select is one-hot
package lfr_pkg;
    // which store answers a pending read
    typedef enum logic [2:0] {
        LFR_SEL_NONE = 3'b001,
        LFR_SEL_FLAG = 3'b010,
        LFR_SEL_CUR = 3'b100
    } lfr_sel_t;

    typedef logic [1:0] lfr_idx_t;
    typedef logic [5:0] lfr_code_t;
endpackage

// ---- rtl/lfr_cur_if.sv ----
// Purpose: carrier between register top and current setting store
// Assumes: single clock domain
// Notes:   write and read index are decoded by the top
`timescale 1ns/10ps
`default_nettype none
interface lfr_cur_if;
    import lfr_pkg::*;
    logic wr_en;
    lfr_idx_t wr_idx;
    lfr_code_t wr_code;
    lfr_idx_t rd_idx;
    lfr_code_t rd_code;
    lfr_code_t code0;
    lfr_code_t code1;
    lfr_code_t code2;

    modport store (
        input wr_en, wr_idx, wr_code, rd_idx,
        output rd_code, code0, code1, code2
    );
    modport ctrl (
        output wr_en, wr_idx, wr_code, rd_idx,
        input rd_code, code0, code1, code2
    );
endinterface
`default_nettype wire

// ---- rtl/lfr_cur_mem.sv ----
// Purpose: three 6-bit output current setting words with registered read
// Assumes: index decoded by the caller, out-of-range index is never used
// Notes:   a read in the write cycle returns the old word
`include "lfr_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module lfr_cur_mem
    import lfr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // access port
    lfr_cur_if.store cur
);
    lfr_code_t mem_q [`LFR_CUR_ENTRIES];
    lfr_code_t mem_d [`LFR_CUR_ENTRIES];
    lfr_code_t rd_q;
    lfr_code_t rd_d;

    // ----------------------------------------------------------------
    // storage words
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `LFR_CUR_ENTRIES; gi++) begin : g_word
            // only a decoded write to this word changes it
            always_comb begin
                mem_d[gi] = mem_q[gi];
                if (cur.wr_en && (cur.wr_idx == lfr_idx_t'(gi))) begin
                    mem_d[gi] = cur.wr_code;
                end
            end

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    mem_q[gi] <= `LFR_CUR_RST;
                end else begin
                    mem_q[gi] <= mem_d[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // registered read port
    // ----------------------------------------------------------------
    always_comb begin
        rd_d = mem_q[0];
        if (cur.rd_idx == 2'h1) begin
            rd_d = mem_q[1];
        end else if (cur.rd_idx == 2'h2) begin
            rd_d = mem_q[2];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_q <= `LFR_CUR_RST;
        end else begin
            rd_q <= rd_d;
        end
    end

    assign cur.rd_code = rd_q;
    assign cur.code0 = mem_q[0];
    assign cur.code1 = mem_q[1];
    assign cur.code2 = mem_q[2];
endmodule
`default_nettype wire

// ---- rtl/lfr_top.sv ----
// Purpose: fault flag status and output current setting registers
// Assumes: serial port decodes frames and presents one byte access
//          per strobe; fault detectors deliver one-cycle set pulses
// Notes:   reads answer two cycles after the strobe
`include "lfr_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module lfr_top
    import lfr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register access from serial port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // fault detector events
    input wire logic [3:0] open_fault_set_i,
    input wire logic [3:0] open_fault_clr_i,
    input wire logic [11:0] short_fault_set_i,
    input wire logic [11:0] short_fault_clr_i,
    // current codes to the output stages
    output logic [5:0] nv_current_code_zero_o,
    output logic [5:0] nv_current_code_one_o,
    output logic [5:0] nv_current_code_two_o
);
    localparam int NFLAG = 16;

    lfr_cur_if cur ();

    logic [NFLAG-1:0] flag_q;
    logic [NFLAG-1:0] flag_d;
    logic [NFLAG-1:0] set_vec;
    logic [NFLAG-1:0] clr_vec;
    logic [3:0] open_hi;
    logic [7:0] short_lo;
    logic [3:0] short_hi;
    // per-channel views of the sticky flags, named after their channel
    logic open_fault_ch_eight;
    logic open_fault_ch_nine;
    logic open_fault_ch_ten;
    logic open_fault_ch_eleven;
    logic short_fault_ch_zero;
    logic short_fault_ch_one;
    logic short_fault_ch_two;
    logic short_fault_ch_three;
    logic short_fault_ch_four;
    logic short_fault_ch_five;
    logic short_fault_ch_six;
    logic short_fault_ch_seven;
    logic short_fault_ch_eight;
    logic short_fault_ch_nine;
    logic short_fault_ch_ten;
    logic short_fault_ch_eleven;
    lfr_sel_t sel_q;
    lfr_sel_t sel_d;
    logic [7:0] flag_byte_q;
    logic [7:0] flag_byte_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic hit_cur;
    lfr_idx_t cur_idx;

    // ----------------------------------------------------------------
    // fault flags
    // ----------------------------------------------------------------
    // open faults in 15..12, shorts in 11..0
    assign set_vec = {open_fault_set_i, short_fault_set_i};
    assign clr_vec = {open_fault_clr_i, short_fault_clr_i};

    genvar gi;
    generate
        for (gi = 0; gi < NFLAG; gi++) begin : g_flag
            // a set in the clear cycle wins so no event is lost
            always_comb begin
                flag_d[gi] = flag_q[gi];
                if (clr_vec[gi]) begin
                    flag_d[gi] = 1'b0;
                end
                if (set_vec[gi]) begin
                    flag_d[gi] = 1'b1;
                end
            end
        end
    endgenerate

    // flags are reached only through the detector ports
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= {2{`LFR_FLAG_RST}};
        end else begin
            flag_q <= flag_d;
        end
    end

    // open flags sit in 15..12 with channel 8 lowest
    assign open_fault_ch_eight = flag_q[12];
    assign open_fault_ch_nine = flag_q[13];
    assign open_fault_ch_ten = flag_q[14];
    assign open_fault_ch_eleven = flag_q[15];
    // short flags sit in 11..0 with channel 0 lowest
    assign short_fault_ch_zero = flag_q[0];
    assign short_fault_ch_one = flag_q[1];
    assign short_fault_ch_two = flag_q[2];
    assign short_fault_ch_three = flag_q[3];
    assign short_fault_ch_four = flag_q[4];
    assign short_fault_ch_five = flag_q[5];
    assign short_fault_ch_six = flag_q[6];
    assign short_fault_ch_seven = flag_q[7];
    assign short_fault_ch_eight = flag_q[8];
    assign short_fault_ch_nine = flag_q[9];
    assign short_fault_ch_ten = flag_q[10];
    assign short_fault_ch_eleven = flag_q[11];

    // register images, lowest channel in bit 0 of each byte
    assign open_hi = {open_fault_ch_eleven, open_fault_ch_ten,
        open_fault_ch_nine, open_fault_ch_eight};
    assign short_lo = {short_fault_ch_seven, short_fault_ch_six,
        short_fault_ch_five, short_fault_ch_four, short_fault_ch_three,
        short_fault_ch_two, short_fault_ch_one, short_fault_ch_zero};
    assign short_hi = {short_fault_ch_eleven, short_fault_ch_ten,
        short_fault_ch_nine, short_fault_ch_eight};

    // ----------------------------------------------------------------
    // address decode and write path
    // ----------------------------------------------------------------
    always_comb begin
        hit_cur = 1'b1;
        cur_idx = 2'h0;
        case (reg_addr_i)
            `LFR_OFS_CUR_ZERO: cur_idx = 2'h0;
            `LFR_OFS_CUR_ONE: cur_idx = 2'h1;
            `LFR_OFS_CUR_TWO: cur_idx = 2'h2;
            default: hit_cur = 1'b0;
        endcase
    end

    // writes reach only the current words; bits 7..6 are dropped
    assign cur.wr_en = reg_wr_i & hit_cur;
    assign cur.wr_idx = cur_idx;
    assign cur.wr_code = reg_wdata_i[`LFR_CUR_MSB:0];
    assign cur.rd_idx = cur_idx;

    lfr_cur_mem u_cur_mem (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cur(cur.store)
    );

    // ----------------------------------------------------------------
    // read path, first stage
    // ----------------------------------------------------------------
    // flag byte is snapped at the strobe so both sources line up
    always_comb begin
        sel_d = LFR_SEL_NONE;
        flag_byte_d = `LFR_RD_NONE;
        if (reg_rd_i) begin
            if (hit_cur) begin
                sel_d = LFR_SEL_CUR;
            end else begin
                case (reg_addr_i)
                    `LFR_OFS_OPEN_HI: begin
                        sel_d = LFR_SEL_FLAG;
                        flag_byte_d = {`LFR_RSVD_HI, open_hi};
                    end
                    `LFR_OFS_SHORT_LO: begin
                        sel_d = LFR_SEL_FLAG;
                        flag_byte_d = short_lo;
                    end
                    `LFR_OFS_SHORT_HI: begin
                        sel_d = LFR_SEL_FLAG;
                        flag_byte_d = {`LFR_RSVD_HI, short_hi};
                    end
                    default: sel_d = LFR_SEL_FLAG; // unmapped reads zero
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_q <= LFR_SEL_NONE;
            flag_byte_q <= `LFR_RD_NONE;
        end else begin
            sel_q <= sel_d;
            flag_byte_q <= flag_byte_d;
        end
    end

    // ----------------------------------------------------------------
    // read path, second stage
    // ----------------------------------------------------------------
    // last data is held until the next answer
    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        case (sel_q)
            LFR_SEL_NONE: rvalid_d = 1'b0;
            LFR_SEL_FLAG: begin
                rvalid_d = 1'b1;
                rdata_d = flag_byte_q;
            end
            LFR_SEL_CUR: begin
                rvalid_d = 1'b1;
                rdata_d = {`LFR_RSVD_CUR, cur.rd_code};
            end
            default: rvalid_d = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= `LFR_RD_NONE;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reg_rdata_o = rdata_q;
    assign reg_rvalid_o = rvalid_q;
    assign nv_current_code_zero_o = cur.code0;
    assign nv_current_code_one_o = cur.code1;
    assign nv_current_code_two_o = cur.code2;
endmodule
`default_nettype wire

// ---- verif/lfr_top_sva.sv ----
// Purpose: port checks of the flag and current register slice
// Assumes: one clock, synchronous reset, reads answer two cycles on
// Notes: read data of a current word compared with the code outputs
`timescale 1ns/10ps
`default_nettype none
module lfr_top_sva (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    // current codes
    input wire logic [5:0] nv_current_code_zero_o,
    input wire logic [5:0] nv_current_code_one_o,
    input wire logic [5:0] nv_current_code_two_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------
    // access steps
    // ----------------------------------------
    sequence s_rd(a);
        reg_rd_i && !reg_wr_i && reg_addr_i == a;
    endsequence
    sequence s_wr(a);
        reg_wr_i && reg_addr_i == a;
    endsequence
    // a read answers after exactly two edges, never unasked
    property p_rd_lat;
        reg_rd_i |-> ##2 reg_rvalid_o;
    endproperty
    property p_rv_src;
        reg_rvalid_o |-> $past(reg_rd_i, 2);
    endproperty
    // writes land the low six bits only
    property p_wr0;
        s_wr(8'h80) |=> nv_current_code_zero_o == $past(reg_wdata_i[5:0]);
    endproperty
    property p_wr1;
        s_wr(8'h81) |=> nv_current_code_one_o == $past(reg_wdata_i[5:0]);
    endproperty
    property p_wr2;
        s_wr(8'h82) |=> nv_current_code_two_o == $past(reg_wdata_i[5:0]);
    endproperty
    // any other access leaves word zero alone
    property p_keep0;
        !(reg_wr_i && reg_addr_i == 8'h80) |=>
            $stable(nv_current_code_zero_o);
    endproperty
    // second cycle free of writes so the word is steady
    property p_rd_cur;
        s_rd(8'h81) ##1 !reg_wr_i |=>
            reg_rdata_o == {2'h0, $past(nv_current_code_one_o)};
    endproperty
    property p_rsvd_hi;
        (s_rd(8'h7c) or s_rd(8'h7e)) |-> ##2 reg_rdata_o[7:4] == 4'h0;
    endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("read answer not two cycles after strobe");
    a_rv_src: assert property (p_rv_src)
        else $error("read answer without a read strobe");
    a_wr0: assert property (p_wr0)
        else $error("current word zero not written");
    a_wr1: assert property (p_wr1)
        else $error("current word one not written");
    a_wr2: assert property (p_wr2)
        else $error("current word two not written");
    a_keep0: assert property (p_keep0)
        else $error("current word zero changed without its write");
    a_rd_cur: assert property (p_rd_cur)
        else $error("current word one read back wrong");
    a_rsvd_hi: assert property (p_rsvd_hi)
        else $error("reserved flag bits not zero");
endmodule
bind lfr_top lfr_top_sva i_lfr_top_sva (.clk_i, .rst_i, .reg_addr_i,
    .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o,
    .nv_current_code_zero_o, .nv_current_code_one_o,
    .nv_current_code_two_o);
`default_nettype wire

// ---- verif/test_lfr_top.sv ----
// Purpose: register level test of the flag and current slice
// Assumes: reads answer two cycles after strobe
// Notes: fault flags raised and cleared by event pulses
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
    err_total++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_lfr_top;
    logic clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    logic reg_rvalid_o;
    logic [3:0] open_fault_set_i = 4'h0, open_fault_clr_i = 4'h0;
    logic [11:0] short_fault_set_i = 12'h000, short_fault_clr_i = 12'h000;
    logic [5:0] nv_current_code_zero_o, nv_current_code_one_o;
    logic [5:0] nv_current_code_two_o;
    logic [7:0] wv [3] = '{8'hd5, 8'hea, 8'h40};
    int err_total = 0, checked = 0;
    lfr_top i_lfr_top (.clk_i, .rst_i, .reg_addr_i, .reg_wr_i,
        .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o,
        .open_fault_set_i, .open_fault_clr_i, .short_fault_set_i,
        .short_fault_clr_i, .nv_current_code_zero_o,
        .nv_current_code_one_o, .nv_current_code_two_o);
    always #50 clk_i = ~clk_i;
    // ----------------------------------------
    // access tasks, inputs move on the falling edge
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask
    // answer latency is fixed, so no open wait is needed
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        `CHK("rvalid early", 1'b0, reg_rvalid_o)
        @(negedge clk_i);
        `CHK("rvalid", 1'b1, reg_rvalid_o)
        `CHK("rdata", e, reg_rdata_o)
    endtask
    task automatic ev(input logic [3:0] os, oc, input logic [11:0] ss, sc);
        @(negedge clk_i);
        open_fault_set_i = os;
        open_fault_clr_i = oc;
        short_fault_set_i = ss;
        short_fault_clr_i = sc;
        @(negedge clk_i);
        {open_fault_set_i, open_fault_clr_i} = 8'h00;
        {short_fault_set_i, short_fault_clr_i} = 24'h000000;
    endtask
    task automatic summarize;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(negedge clk_i);
        rst_i = 1'b0;
        for (int i = 0; i < 3; i++) begin
            rd(8'(8'h7c + i), 8'h00);
            rd(8'(8'h80 + i), 8'h3f);
        end
        `CHK("code0 reset", 6'h3f, nv_current_code_zero_o)
        // top bits set on purpose, they must be dropped
        for (int i = 0; i < 3; i++) wr(8'(8'h80 + i), wv[i]);
        `CHK("code0", wv[0][5:0], nv_current_code_zero_o)
        `CHK("code1", wv[1][5:0], nv_current_code_one_o)
        `CHK("code2", wv[2][5:0], nv_current_code_two_o)
        for (int i = 0; i < 5; i++) wr(8'(8'h7c + 8'(i % 4)), 8'hff);
        wr(8'h83, 8'hff);
        for (int i = 0; i < 3; i++) begin
            rd(8'(8'h80 + i), {2'h0, wv[i][5:0]});
            rd(8'(8'h7c + i), 8'h00);
        end
        rd(8'h83, 8'h00);
        ev(4'h9, 4'h0, 12'ha5c, 12'h000);
        rd(8'h7c, 8'h09);
        rd(8'h7d, 8'h5c);
        rd(8'h7e, 8'h0a);
        ev(4'h0, 4'hf, 12'h000, 12'hfff);
        ev(4'h6, 4'h6, 12'h5a3, 12'h5a3);
        wr(8'h7d, 8'hff);
        rd(8'h7c, 8'h06);
        rd(8'h7d, 8'ha3);
        rd(8'h7e, 8'h05);
        // reset again mid-run: codes and flags must fall back
        @(negedge clk_i);
        rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        `CHK("code1 reset", 6'h3f, nv_current_code_one_o)
        `CHK("code2 reset", 6'h3f, nv_current_code_two_o)
        `CHK("rvalid reset", 1'b0, reg_rvalid_o)
        rd(8'h7d, 8'h00);
        rd(8'h80, 8'h3f);
        summarize();
    end
endmodule
`default_nettype wire
